// ===== hw/nflt_defines.vh
// Constants for the network command-source filter and signal-loss check.
// Assumes a 250 MHz core clock and a 32-bit AHB-Lite register bus.
`ifndef NFLT_DEFINES_VH
`define NFLT_DEFINES_VH

// ==========================================================================
// Register word offsets (bus address bits 7:2)
`define NFLT_A_CTRL 6'h00
`define NFLT_A_INTERVAL 6'h01
`define NFLT_A_OCT1 6'h02
`define NFLT_A_OCT2 6'h03
`define NFLT_A_OCT3 6'h04
`define NFLT_A_OCT4 6'h05
`define NFLT_A_OCT3_RANGE 6'h06
`define NFLT_A_OCT4_RANGE 6'h07
`define NFLT_A_SLOT0 6'h08
`define NFLT_A_SLOT1 6'h09
`define NFLT_A_SLOT2 6'h0a
`define NFLT_A_SLOT3 6'h0b
`define NFLT_A_STATUS 6'h0c
`define NFLT_A_MASK 6'h0d
`define NFLT_A_STATE 6'h0e

// ==========================================================================
// Field positions
`define NFLT_CTRL_NETMODE 0
`define NFLT_CTRL_NETSRC 1
`define NFLT_CTRL_APPLY 8
`define NFLT_EV_FAULT 0
`define NFLT_EV_REJECT 1
`define NFLT_EV_W 2

// ==========================================================================
// Setting codes and reset values
`define NFLT_CODE_OFF 16'h270f
`define NFLT_INTERVAL_MAX 16'h270e
`define NFLT_INTERVAL_RST 16'h0000
`define NFLT_OCT_RST 8'h00
`define NFLT_RANGE_RST 16'h270f
`define NFLT_PROTO_PORT 16'haf12
`define NFLT_PROTO_RIVAL 16'hb0b6
`define NFLT_SLOT0_RST 16'h1389
`define NFLT_SLOT1_RST 16'hb0b5
`define NFLT_SLOT2_RST 16'hb0b6
`define NFLT_SLOT3_RST 16'h270f

// ==========================================================================
// Timing: one interval step is 0.1 s
`define NFLT_STEP_NS 100000000
`define NFLT_CLK_NS 4

// ==========================================================================
// AHB-Lite codes
`define NFLT_HTRANS_NONSEQ 2'b10
`define NFLT_HSIZE_WORD 3'b010
`define NFLT_HRESP_OKAY 1'b0

`endif

// ===== hw/nflt_filter.v
// Network command-source address filter and signal-loss supervisor.
// Assumes frame reports come from the receive logic on I_MCLK, one pulse
// per received frame, and that the AHB-Lite master is the only bus master.
`timescale 1ns/1ps
`include "nflt_defines.vh"

// Summary of operation
// - Interval zero: output shut off in network mode; fault at once if network operation is active outside start-up.
// - Interval 0.1 to 999.8 s: shut off after silence longer than interval.
// - Interval at disable code: no signal-loss detection at all.
// - Silence toward all permitted peers raises communication fault and shuts output.
// - Interval zero, network start-up mode: one exchange, then communication fault.
// - Interval zero: monitor and parameter reads still served before network mode.
// - All four octets zero: no command source, network operation commands rejected.
// - Four octet settings, 0 to 255 each, reset to zero.
// - Third and fourth octets accepted between setting and range, either order.
// - Range at disable code means that octet must match exactly.
// - Protocol enabled by port code in a slot; rival code wins.
// - Address and function settings take effect only after device reset.
// - Loss timer starts at first permitted frame in network mode with network source.
module nflt_filter #(
	parameter STEP_CYCLES = `NFLT_STEP_NS / `NFLT_CLK_NS
) (
	input wire I_MCLK,
	input wire I_NRST,
	input wire I_CE,
	input wire I_HSEL,
	input wire [31:0] I_HADDR,
	input wire [1:0] I_HTRANS,
	input wire I_HWRITE,
	input wire [2:0] I_HSIZE,
	input wire [31:0] I_HWDATA,
	input wire I_HREADY,
	input wire I_FRAME_VALID,
	input wire [31:0] I_FRAME_SRC_IP,
	input wire I_FRAME_IS_CMD,
	output reg [31:0] O_HRDATA,
	output reg O_HREADYOUT,
	output reg O_HRESP,
	output reg O_OUTPUT_SHUTOFF,
	output reg O_COMM_FAULT,
	output reg O_PROTO_EN,
	output reg O_FRAME_SERVED,
	output reg O_CMD_ACCEPT,
	output reg O_CMD_REJECT,
	output reg O_IRQ
);

	// ======================================================================
	// Helpers

	// An octet matches an inclusive window whose ends may come in either order.
	function in_window;
		input [7:0] val;
		input [7:0] base;
		input [15:0] range;
		begin
			if (range == `NFLT_CODE_OFF) begin
				in_window = (val == base);
			end else if (base <= range[7:0]) begin
				in_window = (val >= base) && (val <= range[7:0]);
			end else begin
				in_window = (val >= range[7:0]) && (val <= base);
			end
		end
	endfunction

	// ======================================================================
	// Declarations
	reg [1:0] ctrl_reg;
	reg [15:0] interval_reg;
	reg [7:0] oct1_reg, oct2_reg, oct3_reg, oct4_reg;
	reg [15:0] range3_reg, range4_reg;
	reg [15:0] slot0_reg, slot1_reg, slot2_reg, slot3_reg;
	reg [7:0] act1_reg, act2_reg, act3_reg, act4_reg;
	reg [15:0] act_range3_reg, act_range4_reg;
	reg proto_en_next;
	reg [`NFLT_EV_W-1:0] status_reg, mask_reg;
	reg wr_pend_reg;
	reg [5:0] wr_idx_reg;
	reg apply_reg;
	reg armed_reg;
	reg startup_reg;
	reg fault_reg;
	reg net_prev_reg;
	reg [31:0] tick_cnt_reg;
	reg [15:0] step_cnt_reg;
	wire [5:0] a_idx;
	wire a_valid;
	wire wr_apply;
	wire net_active;
	wire frame_ok;
	wire check_on;
	wire int_zero;
	wire loss_hit;
	wire zero_fault;
	wire fault_set;
	wire [`NFLT_EV_W-1:0] ev_set;
	wire [31:0] step_last;
	reg [31:0] rd_data;

	// ======================================================================
	// Bus address phase decode.
	assign a_idx = I_HADDR[7:2];
	assign a_valid = I_HSEL && I_HREADY && (I_HTRANS == `NFLT_HTRANS_NONSEQ);
	assign wr_apply = wr_pend_reg && (wr_idx_reg == `NFLT_A_CTRL) &&
		I_HWDATA[`NFLT_CTRL_APPLY];

	// Read mux; unmapped words read as zero, answer is always OKAY.
	always @* begin
		rd_data = 32'h0000_0000;
		case (a_idx)
			`NFLT_A_CTRL: rd_data[1:0] = ctrl_reg;
			`NFLT_A_INTERVAL: rd_data[15:0] = interval_reg;
			`NFLT_A_OCT1: rd_data[7:0] = oct1_reg;
			`NFLT_A_OCT2: rd_data[7:0] = oct2_reg;
			`NFLT_A_OCT3: rd_data[7:0] = oct3_reg;
			`NFLT_A_OCT4: rd_data[7:0] = oct4_reg;
			`NFLT_A_OCT3_RANGE: rd_data[15:0] = range3_reg;
			`NFLT_A_OCT4_RANGE: rd_data[15:0] = range4_reg;
			`NFLT_A_SLOT0: rd_data[15:0] = slot0_reg;
			`NFLT_A_SLOT1: rd_data[15:0] = slot1_reg;
			`NFLT_A_SLOT2: rd_data[15:0] = slot2_reg;
			`NFLT_A_SLOT3: rd_data[15:0] = slot3_reg;
			`NFLT_A_STATUS: rd_data[`NFLT_EV_W-1:0] = status_reg;
			`NFLT_A_MASK: rd_data[`NFLT_EV_W-1:0] = mask_reg;
			`NFLT_A_STATE: rd_data[4:0] = {startup_reg, armed_reg, O_PROTO_EN,
				O_COMM_FAULT, O_OUTPUT_SHUTOFF};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ======================================================================
	// AHB-Lite slave: zero wait states, read data registered in address phase.
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			O_HRDATA <= 32'h0000_0000;
			O_HREADYOUT <= 1'b0;
			O_HRESP <= `NFLT_HRESP_OKAY;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 6'h00;
		end else if (I_CE) begin
			O_HREADYOUT <= 1'b1;
			O_HRESP <= `NFLT_HRESP_OKAY;
			wr_pend_reg <= a_valid && I_HWRITE;
			wr_idx_reg <= a_idx;
			if (a_valid && !I_HWRITE) begin
				O_HRDATA <= rd_data;
			end
		end
	end

	// ======================================================================
	// Software-visible settings, written in the data phase.
	// setting registers
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			ctrl_reg <= 2'b00;
			interval_reg <= `NFLT_INTERVAL_RST;
			oct1_reg <= `NFLT_OCT_RST;
			oct2_reg <= `NFLT_OCT_RST;
			oct3_reg <= `NFLT_OCT_RST;
			oct4_reg <= `NFLT_OCT_RST;
			range3_reg <= `NFLT_RANGE_RST;
			range4_reg <= `NFLT_RANGE_RST;
			slot0_reg <= `NFLT_SLOT0_RST;
			slot1_reg <= `NFLT_SLOT1_RST;
			slot2_reg <= `NFLT_SLOT2_RST;
			slot3_reg <= `NFLT_SLOT3_RST;
			mask_reg <= {`NFLT_EV_W{1'b0}};
		end else if (I_CE && wr_pend_reg) begin
			case (wr_idx_reg)
				`NFLT_A_CTRL: ctrl_reg <= I_HWDATA[1:0];
				`NFLT_A_INTERVAL: interval_reg <= I_HWDATA[15:0];
				`NFLT_A_OCT1: oct1_reg <= I_HWDATA[7:0];
				`NFLT_A_OCT2: oct2_reg <= I_HWDATA[7:0];
				`NFLT_A_OCT3: oct3_reg <= I_HWDATA[7:0];
				`NFLT_A_OCT4: oct4_reg <= I_HWDATA[7:0];
				`NFLT_A_OCT3_RANGE: range3_reg <= I_HWDATA[15:0];
				`NFLT_A_OCT4_RANGE: range4_reg <= I_HWDATA[15:0];
				`NFLT_A_SLOT0: slot0_reg <= I_HWDATA[15:0];
				`NFLT_A_SLOT1: slot1_reg <= I_HWDATA[15:0];
				`NFLT_A_SLOT2: slot2_reg <= I_HWDATA[15:0];
				`NFLT_A_SLOT3: slot3_reg <= I_HWDATA[15:0];
				`NFLT_A_MASK: mask_reg <= I_HWDATA[`NFLT_EV_W-1:0];
				default: mask_reg <= mask_reg;
			endcase
		end
	end

	// ======================================================================
	// Effective copies. The apply bit acts as the device reset for settings,
	// so a half-written address window never steers live traffic.
	// protocol selection
	always @* begin
		proto_en_next = 1'b0;
		if ((slot0_reg == `NFLT_PROTO_PORT) || (slot1_reg == `NFLT_PROTO_PORT) ||
			(slot2_reg == `NFLT_PROTO_PORT) || (slot3_reg == `NFLT_PROTO_PORT)) begin
			proto_en_next = 1'b1;
		end
		if ((slot0_reg == `NFLT_PROTO_RIVAL) || (slot1_reg == `NFLT_PROTO_RIVAL) ||
			(slot2_reg == `NFLT_PROTO_RIVAL) || (slot3_reg == `NFLT_PROTO_RIVAL)) begin
			proto_en_next = 1'b0;
		end
	end

	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			act1_reg <= `NFLT_OCT_RST;
			act2_reg <= `NFLT_OCT_RST;
			act3_reg <= `NFLT_OCT_RST;
			act4_reg <= `NFLT_OCT_RST;
			act_range3_reg <= `NFLT_RANGE_RST;
			act_range4_reg <= `NFLT_RANGE_RST;
			O_PROTO_EN <= 1'b0;
			apply_reg <= 1'b1;
		end else if (I_CE) begin
			apply_reg <= wr_apply;
			if (apply_reg) begin
				act1_reg <= oct1_reg;
				act2_reg <= oct2_reg;
				act3_reg <= oct3_reg;
				act4_reg <= oct4_reg;
				act_range3_reg <= range3_reg;
				act_range4_reg <= range4_reg;
				O_PROTO_EN <= proto_en_next;
			end
		end
	end

	// ======================================================================
	// Frame classification.
	assign net_active = ctrl_reg[`NFLT_CTRL_NETMODE] && ctrl_reg[`NFLT_CTRL_NETSRC];
	assign frame_ok = I_FRAME_VALID &&
		((act1_reg | act2_reg | act3_reg | act4_reg) != 8'h00) &&
		(I_FRAME_SRC_IP[31:24] == act1_reg) && (I_FRAME_SRC_IP[23:16] == act2_reg) &&
		in_window(I_FRAME_SRC_IP[15:8], act3_reg, act_range3_reg) &&
		in_window(I_FRAME_SRC_IP[7:0], act4_reg, act_range4_reg);

	// Frame answers: reads are always served, commands need a permitted source.
	// reads served, commands accepted or rejected
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			O_FRAME_SERVED <= 1'b0;
			O_CMD_ACCEPT <= 1'b0;
			O_CMD_REJECT <= 1'b0;
		end else if (I_CE) begin
			O_FRAME_SERVED <= I_FRAME_VALID && !I_FRAME_IS_CMD;
			O_CMD_ACCEPT <= frame_ok && I_FRAME_IS_CMD && !fault_reg;
			O_CMD_REJECT <= I_FRAME_VALID && I_FRAME_IS_CMD && (!frame_ok || fault_reg);
		end
	end

	// ======================================================================
	// Signal-loss timer, counted in 0.1 s steps.
	assign int_zero = (interval_reg == 16'h0000);
	assign check_on = !int_zero && (interval_reg <= `NFLT_INTERVAL_MAX);
	assign step_last = STEP_CYCLES - 1;
	assign loss_hit = armed_reg && check_on && (step_cnt_reg >= interval_reg) &&
		(tick_cnt_reg == step_last) && !frame_ok;
	assign zero_fault = int_zero && net_active &&
		(!startup_reg || (frame_ok && net_prev_reg)) && !(startup_reg && !frame_ok);
	assign fault_set = (loss_hit || zero_fault) && !fault_reg;

	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			armed_reg <= 1'b0;
			tick_cnt_reg <= 32'h0000_0000;
			step_cnt_reg <= 16'h0000;
		end else if (I_CE) begin
			if (!net_active || !check_on || apply_reg) begin
				armed_reg <= 1'b0;
				tick_cnt_reg <= 32'h0000_0000;
				step_cnt_reg <= 16'h0000;
			end else if (frame_ok) begin
				armed_reg <= 1'b1;
				tick_cnt_reg <= 32'h0000_0000;
				step_cnt_reg <= 16'h0000;
			end else if (armed_reg) begin
				if (tick_cnt_reg == step_last) begin
					tick_cnt_reg <= 32'h0000_0000;
					if (step_cnt_reg != `NFLT_CODE_OFF) begin
						step_cnt_reg <= step_cnt_reg + 16'h0001;
					end
				end else begin
					tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
				end
			end
		end
	end

	// ======================================================================
	// Fault and output shut-off. Fault stays until the apply bit resets it;
	// a running drive must not restart on its own after a link loss.
	// fault and shut off
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			fault_reg <= 1'b0;
			startup_reg <= 1'b1;
			net_prev_reg <= 1'b0;
			O_COMM_FAULT <= 1'b0;
			O_OUTPUT_SHUTOFF <= 1'b0;
		end else if (I_CE) begin
			net_prev_reg <= net_active;
			if (apply_reg) begin
				fault_reg <= 1'b0;
				startup_reg <= 1'b1;
			end else begin
				if (fault_set) begin
					fault_reg <= 1'b1;
				end
				if (frame_ok || (net_active && !net_prev_reg && !startup_reg) ||
					(!net_active && net_prev_reg)) begin
					startup_reg <= 1'b0;
				end else if (!net_active && !net_prev_reg) begin
					startup_reg <= 1'b0;
				end
			end
			O_COMM_FAULT <= fault_reg || fault_set;
			O_OUTPUT_SHUTOFF <= fault_reg || fault_set ||
				(int_zero && ctrl_reg[`NFLT_CTRL_NETMODE]);
		end
	end

	// ======================================================================
	// Sticky event status, write one to clear; a new event beats the clear.
	assign ev_set = {O_CMD_REJECT, fault_set};
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			status_reg <= {`NFLT_EV_W{1'b0}};
			O_IRQ <= 1'b0;
		end else if (I_CE) begin
			if (wr_pend_reg && (wr_idx_reg == `NFLT_A_STATUS)) begin
				status_reg <= (status_reg & ~I_HWDATA[`NFLT_EV_W-1:0]) | ev_set;
			end else begin
				status_reg <= status_reg | ev_set;
			end
			O_IRQ <= |(status_reg & mask_reg);
		end
	end

endmodule // nflt_filter

// ===== sim/nflt_monitor.sv
// Port checker for the command-source filter and loss supervisor.
// Assumes it is bound to nflt_filter, with one AHB-Lite master on the bus.
`timescale 1ns/1ps
module nflt_monitor (
	input wire I_MCLK,
	input wire I_NRST,
	input wire I_CE,
	input wire I_HSEL,
	input wire [31:0] I_HADDR,
	input wire [1:0] I_HTRANS,
	input wire I_HWRITE,
	input wire I_HREADY,
	input wire I_FRAME_VALID,
	input wire I_FRAME_IS_CMD,
	input wire [31:0] O_HRDATA,
	input wire O_HREADYOUT,
	input wire O_OUTPUT_SHUTOFF,
	input wire O_COMM_FAULT,
	input wire O_PROTO_EN,
	input wire O_FRAME_SERVED,
	input wire O_CMD_ACCEPT,
	input wire O_CMD_REJECT
);
	// ====================
	// Qualified requests
	// A bus request or a frame only counts on an enabled edge.
	wire take = I_HSEL && I_HREADY && I_HTRANS == 2'b10 && I_CE;
	wire frame = I_FRAME_VALID && I_CE;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_NRST);
	// ====================
	// Bus answers
	// The slave never stalls, and holes in the map read as zero.
	a_zero_wait: assert property (take |=> O_HREADYOUT)
		else $error("bus transfer not answered at once");
	a_unmapped_zero: assert property (take && !I_HWRITE && I_HADDR[7:2] > 6'h0e
		|=> O_HRDATA == 32'h0) else $error("unmapped read not zero");
	// ====================
	// Frame answers
	// Each command, and each read while no fault is shown, gets exactly one answer on the next cycle, and none without one.
	a_cmd_answer: assert property (frame && I_FRAME_IS_CMD
		|=> O_CMD_ACCEPT != O_CMD_REJECT && !O_FRAME_SERVED) else $error("command answer");
	a_served_frame: assert property (frame && !I_FRAME_IS_CMD && !O_COMM_FAULT
		|=> O_FRAME_SERVED && !O_CMD_ACCEPT) else $error("frame not served");
	// A frozen edge holds the last answer, so only an enabled idle edge must clear it.
	a_quiet_outputs: assert property (!I_FRAME_VALID && I_CE
		|=> !O_CMD_ACCEPT && !O_CMD_REJECT && !O_FRAME_SERVED) else $error("stray pulse");
	// ====================
	// Fault behaviour
	// A fault shuts the output, refuses commands, and lasts until an apply write.
	a_fault_shuts: assert property ($rose(O_COMM_FAULT) |-> ##[0:1] O_OUTPUT_SHUTOFF)
		else $error("fault without shutoff");
	a_fault_rejects: assert property (O_COMM_FAULT && frame && I_FRAME_IS_CMD
		|=> O_CMD_REJECT) else $error("command taken while faulted");
	a_fault_holds: assert property (O_COMM_FAULT && !I_HSEL && !$past(I_HSEL)
		&& !$past(I_HSEL, 2) && !$past(I_HSEL, 3) && !$past(I_HSEL, 4) |=> O_COMM_FAULT)
		else $error("fault cleared without apply");
	// Protocol choice moves only a few cycles after a bus write, never on its own.
	a_proto_staged: assert property ($changed(O_PROTO_EN) && $past(I_NRST)
		&& $past(I_NRST, 2) |-> $past(I_HSEL, 2) || $past(I_HSEL, 3) || $past(I_HSEL, 4))
		else $error("protocol enable moved without apply");
endmodule // nflt_monitor

// ===== sim/nflt_peer.sv
// Network master model: sends one frame per request on the filter clock.
// Assumes the bench raises i_req for one cycle with the frame fields.
`timescale 1ns/1ps
module nflt_peer (
	input wire i_clk,
	input wire i_req,
	input wire [31:0] i_ip,
	input wire i_cmd,
	output reg o_valid = 1'b0,
	output reg [31:0] o_ip = 32'h0,
	output reg o_cmd = 1'b0
);
	// ====================
	// Frame launch
	// pacing from bench
	// Fields toggle between frames, so stale data can never pass for a frame.
	always @(posedge i_clk) begin
		o_valid <= i_req;
		o_ip <= i_req ? i_ip : ~o_ip;
		o_cmd <= i_req ? i_cmd : ~o_cmd;
	end
endmodule // nflt_peer

// ===== sim/tb.sv
// Bench for nflt_filter: bus tasks, a peer model and the scenario sequence.
// Assumes STEP_CYCLES is cut to 10, so one 0.1 s step lasts 10 clocks.
`timescale 1ns/1ps
`include "nflt_defines.vh"
module tb;
	localparam logic [2:0] e_acc = 3'b100, e_rej = 3'b010, e_srv = 3'b001;
	localparam logic [31:0] pip = 32'hc0a80164, fip_far = 32'h0a000001;
	logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, rq = 1'b0, fc = 1'b0;
	logic ce = 1'b1;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, fip = 32'h0, hrdata, rdat, sip;
	logic hready, hresp, shut, fault, proto, served, acc, rej, irq, fv, fcmd;
	int miscompares = 0, comparisons = 0, cycles = 0;
	logic [31:0] rtab [1:11] = '{0, 0, 0, 0, 0, 9999, 9999, 5001, 45237, 45238, 9999};
	logic [32:0] ftab [12] = '{33'h1c0a83264, 33'h1c0a8326e, 33'h0c0a8326f, 33'h0c0a83263,
		33'h0c0a83369, 33'h0c0a93269, 33'h1c0a80164, 33'h1c0a80396, 33'h1c0a80278,
		33'h0c0a80478, 33'h0c0a80197, 33'h0c0a80063};
	nflt_filter #(.STEP_CYCLES(10)) i_nflt_filter (.I_MCLK(clk), .I_NRST(nrst), .I_CE(ce),
		.I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(`NFLT_HSIZE_WORD), .I_HWDATA(hwdata), .I_HREADY(hready),
		.I_FRAME_VALID(fv), .I_FRAME_SRC_IP(sip), .I_FRAME_IS_CMD(fcmd), .O_HRDATA(hrdata),
		.O_HREADYOUT(hready), .O_HRESP(hresp), .O_OUTPUT_SHUTOFF(shut), .O_COMM_FAULT(fault),
		.O_PROTO_EN(proto), .O_FRAME_SERVED(served), .O_CMD_ACCEPT(acc), .O_CMD_REJECT(rej),
		.O_IRQ(irq));
	nflt_peer i_nflt_peer (.i_clk(clk), .i_req(rq), .i_ip(fip), .i_cmd(fc), .o_valid(fv),
		.o_ip(sip), .o_cmd(fcmd));
	// ====================
	// Clock and watchdog
	// The watchdog ends a hung handshake; the tests need far fewer cycles.
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end
	// ====================
	// Shared tasks
	// Verdict, printed once for the whole run.
	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic flg(input logic f, input logic e);
		chk({31'h0, f}, {31'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One single AHB-Lite transfer; data are taken at the data-phase edge.
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= `NFLT_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a, 2'b00};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rdat = hrdata;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
		flg(hresp, `NFLT_HRESP_OKAY);
	endtask
	// Control write with the apply bit, then time for the copies to load.
	task automatic apply(input logic [31:0] c);
		wr(`NFLT_A_CTRL, c);
		cyc(3);
	endtask
	// Sends one frame and checks the {accept, reject, served} answer pulse.
	task automatic frm(input logic [31:0] ip, input logic c, input logic [2:0] e);
		rq <= 1'b1;
		fip <= ip;
		fc <= c;
		@(posedge clk);
		rq <= 1'b0;
		repeat (2) @(posedge clk);
		chk({29'h0, acc, rej, served}, {29'h0, e});
	endtask
	// ====================
	// Scenarios
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 1; i < 12; i++)
			rd(i[5:0], rtab[i]);
		rd(6'h0f, 0);
		flg(proto, 1'b0);
		// A slot change waits for apply; the rival code wins over the port code.
		wr(`NFLT_A_SLOT2, 44818);
		cyc(4);
		flg(proto, 1'b0);
		apply('h100);
		flg(proto, 1'b1);
		wr(`NFLT_A_SLOT3, 45238);
		apply('h100);
		flg(proto, 1'b0);
		// With no source octets every command is refused and can interrupt.
		wr(`NFLT_A_MASK, 2);
		frm(pip, 1'b1, e_rej);
		cyc(3);
		flg(irq, 1'b1);
		rd(`NFLT_A_STATUS, 2);
		wr(`NFLT_A_STATUS, 2);
		cyc(3);
		flg(irq, 1'b0);
		wr(`NFLT_A_MASK, 0);
		frm(pip, 1'b1, e_rej);
		cyc(3);
		flg(irq, 1'b0);
		// Exact third octet with a fourth range, then a reversed third range and a wider fourth range.
		wr(`NFLT_A_OCT1, 192);
		wr(`NFLT_A_OCT2, 168);
		wr(`NFLT_A_OCT3, 50);
		wr(`NFLT_A_OCT4, 100);
		wr(`NFLT_A_OCT4_RANGE, 110);
		frm(32'hc0a83264, 1'b1, e_rej);
		apply('h100);
		for (int i = 0; i < 12; i++) begin
			if (i == 6) begin
				wr(`NFLT_A_OCT3, 3);
				wr(`NFLT_A_OCT3_RANGE, 1);
				wr(`NFLT_A_OCT4_RANGE, 150);
				apply('h100);
			end
			frm(ftab[i][31:0], 1'b1, ftab[i][32] ? e_acc : e_rej);
		end
		// Interval zero: reads are served before network mode is entered.
		frm(pip, 1'b0, e_srv);
		flg(shut, 1'b0);
		// Network operation mode alone already shuts the output at interval zero.
		wr(`NFLT_A_CTRL, 1);
		cyc(3);
		flg(shut, 1'b1);
		wr(`NFLT_A_CTRL, 3);
		cyc(3);
		flg(shut, 1'b1);
		flg(fault, 1'b1);
		frm(pip, 1'b1, e_rej);
		apply('h103);
		flg(fault, 1'b0);
		flg(shut, 1'b1);
		frm(pip, 1'b0, e_srv);
		cyc(1);
		flg(fault, 1'b1);
		// Loss timer: armed by the first permitted frame, kept alive by permitted frames only.
		apply('h100);
		wr(`NFLT_A_INTERVAL, 3);
		wr(`NFLT_A_CTRL, 3);
		cyc(100);
		flg(fault, 1'b0);
		wr(`NFLT_A_STATUS, 3);
		repeat (4) begin
			frm(pip, 1'b0, e_srv);
			cyc(20);
		end
		// A low clock enable freezes the loss timer, so a long pause must not fault.
		ce <= 1'b0;
		cyc(60);
		ce <= 1'b1;
		flg(fault, 1'b0);
		rd(`NFLT_A_STATE, 32'h8);
		cyc(4);
		frm(fip_far, 1'b0, e_srv);
		flg(fault, 1'b0);
		for (int i = 0; i < 15 && !fault; i++)
			frm(fip_far, 1'b0, e_srv);
		flg(fault, 1'b1);
		flg(shut, 1'b1);
		rd(`NFLT_A_STATUS, 32'h1);
		wr(`NFLT_A_INTERVAL, 9999);
		apply('h103);
		frm(pip, 1'b1, e_acc);
		cyc(150);
		flg(fault, 1'b0);
		flg(shut, 1'b0);
		stop_test();
	end
endmodule // tb
bind nflt_filter nflt_monitor i_nflt_monitor (.I_MCLK, .I_NRST, .I_CE, .I_HSEL, .I_HADDR,
	.I_HTRANS, .I_HWRITE, .I_HREADY, .I_FRAME_VALID, .I_FRAME_IS_CMD, .O_HRDATA,
	.O_HREADYOUT, .O_OUTPUT_SHUTOFF, .O_COMM_FAULT, .O_PROTO_EN, .O_FRAME_SERVED,
	.O_CMD_ACCEPT, .O_CMD_REJECT);
